// *** inc/ddrbr_regs.vh ***
`ifndef DDRBR_REGS_VH
`define DDRBR_REGS_VH
// command encodings {cs_n, ras_n, cas_n, we_n}
`define DDRBR_CMD_REF 4'h1
`define DDRBR_CMD_ACT 4'h3
`define DDRBR_CMD_RD 4'h5
`define DDRBR_CMD_WR 4'h4
`define DDRBR_CMD_PRE 4'h2
// mode register zero burst-length field
`define DDRBR_BL_FIXED8 2'h0
`define DDRBR_BL_OTF 2'h1
`define DDRBR_BL_FIXED4 2'h2
// address bit positions
`define DDRBR_CHOP_BIT 12
`define DDRBR_AP_BIT 10
// beats per burst
`define DDRBR_BEATS8 4'h8
`define DDRBR_BEATS4 4'h4
// renewal cycle time in ns, cycles at 100 MHz (least time, rounded up)
`define DDRBR_RENEW_NS 260
`define DDRBR_RENEW_CYC ((`DDRBR_RENEW_NS + 9) / 10)
`endif

// *** hw/ddrbr_core.v ***
`timescale 1ns/1ns
`include "ddrbr_regs.vh"
// Functional notes
// - in on-the-fly mode, chop bit low gives four-beat burst, high gives eight-beat, any auto-precharge.
// - chop bit never forms part of the column address.
// - eight beats when mode is fixed eight, or on-the-fly with chop bit high.
// - read data is only driven while the delay-locked loop is locked.
// - bad write data setup or hold only corrupts the addressed location.
// - bad write strobe timing only corrupts the addressed location, never hangs.
// - refresh decoded when chip select, row and column strobe low, write enable high.
// - refresh rows come from an internal counter, external address ignored.
// - after refresh every bank is precharged and idle.
// - precharged bank is idle and needs activation before read or write.
module ddrbr_core #(
  parameter ROW_W = 16,
  parameter COL_W = 10,
  parameter DATA_W = 8,
  parameter ADDITIVE_LATENCY = 0,
  parameter READ_COLUMN_LATENCY = 6,
  parameter WRITE_COLUMN_LATENCY = 5
) (
  // system
  input wire clk_sys,
  input wire rst,
  // link pins
  input wire ck,
  input wire cs_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire [2:0] ba,
  input wire [15:0] addr,
  input wire [DATA_W-1:0] dq_in,
  output reg [DATA_W-1:0] dq_out,
  output reg dq_oe,
  // configuration
  input wire [1:0] bl_mode,
  input wire dll_locked,
  // memory side
  output reg mem_we,
  output reg mem_re,
  output reg [2:0] mem_ba,
  output reg [ROW_W-1:0] mem_row,
  output reg [COL_W-1:0] mem_col,
  output reg [DATA_W-1:0] mem_wdata,
  input wire [DATA_W-1:0] mem_rdata,
  // status
  output reg refresh_busy,
  output reg [ROW_W-1:0] refresh_row,
  output reg [7:0] bank_open,
  output reg cmd_error
);
  localparam READ_LATENCY = ADDITIVE_LATENCY + READ_COLUMN_LATENCY;
  localparam WRITE_LATENCY = ADDITIVE_LATENCY + WRITE_COLUMN_LATENCY;
  // burst state loads one link edge early so beat zero lands on the latency edge
  localparam RD_TAP = READ_LATENCY - 2;
  localparam WR_TAP = WRITE_LATENCY - 2;
  // command pins, bank and full address
  localparam PIPE_W = 23;
  localparam PIPE_D = 32;
  localparam [15:0] RENEW_CYC = `DDRBR_RENEW_CYC;

  // two-flop synchronisers for every link input
  reg [PIPE_W-1:0] s1_r, s2_r;
  reg ck1_r, ck2_r, ck3_r;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_r <= {PIPE_W{1'b0}};
      s2_r <= {PIPE_W{1'b0}};
      ck1_r <= 1'b0;
      ck2_r <= 1'b0;
      ck3_r <= 1'b0;
    end else begin
      s1_r <= {cs_n, ras_n, cas_n, we_n, ba, addr};
      s2_r <= s1_r;
      ck1_r <= ck;
      ck2_r <= ck1_r;
      ck3_r <= ck2_r;
    end
  end
  reg [DATA_W-1:0] d1_r, d2_r;
  reg l1_r, l2_r;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      d1_r <= {DATA_W{1'b0}};
      d2_r <= {DATA_W{1'b0}};
      l1_r <= 1'b0;
      l2_r <= 1'b0;
    end else begin
      d1_r <= dq_in;
      d2_r <= d1_r;
      l1_r <= dll_locked;
      l2_r <= l1_r;
    end
  end

  wire ck_rise = ck2_r & ~ck3_r;
  wire [3:0] cmd = s2_r[PIPE_W-1:PIPE_W-4];
  wire [2:0] cba = s2_r[PIPE_W-5:PIPE_W-7];
  wire [15:0] caddr = s2_r[PIPE_W-8:PIPE_W-23];
  wire dll_ok = l2_r;

  function [3:0] beats_of;
    input [1:0] mode;
    input chop;
    begin
      case (mode)
        `DDRBR_BL_FIXED8: beats_of = `DDRBR_BEATS8;
        `DDRBR_BL_OTF: beats_of = chop ? `DDRBR_BEATS8 : `DDRBR_BEATS4;
        default: beats_of = `DDRBR_BEATS4;
      endcase
    end
  endfunction

  // open rows per bank
  reg [ROW_W-1:0] open_row_r [0:7];
  integer i;

  // column pipeline: slot per link-clock delay
  reg [PIPE_D-1:0] rd_p_r, wr_p_r;
  reg [COL_W-1:0] col_r [0:PIPE_D-1];
  reg [2:0] pba_r [0:PIPE_D-1];
  reg [3:0] pbeats_r [0:PIPE_D-1];
  reg [3:0] beat_r;
  reg [3:0] blen_r;
  reg [1:0] dir_r;
  reg [COL_W-1:0] bcol_r;
  reg [2:0] bba_r;
  reg [15:0] rfc_cnt_r;

  wire is_col = ck_rise && (cmd == `DDRBR_CMD_RD || cmd == `DDRBR_CMD_WR);
  // chop bit only picks length; column taken from low bits only
  wire [COL_W-1:0] ccol = caddr[COL_W-1:0];
  wire cchop = caddr[`DDRBR_CHOP_BIT];

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_p_r <= {PIPE_D{1'b0}};
      wr_p_r <= {PIPE_D{1'b0}};
      beat_r <= 4'h0;
      blen_r <= 4'h0;
      dir_r <= 2'h0;
      bcol_r <= {COL_W{1'b0}};
      bba_r <= 3'h0;
      rfc_cnt_r <= 16'h0;
      refresh_busy <= 1'b0;
      refresh_row <= {ROW_W{1'b0}};
      bank_open <= 8'h0;
      cmd_error <= 1'b0;
      mem_we <= 1'b0;
      mem_re <= 1'b0;
      mem_ba <= 3'h0;
      mem_row <= {ROW_W{1'b0}};
      mem_col <= {COL_W{1'b0}};
      mem_wdata <= {DATA_W{1'b0}};
      dq_out <= {DATA_W{1'b0}};
      dq_oe <= 1'b0;
      for (i = 0; i < 8; i = i + 1)
        open_row_r[i] <= {ROW_W{1'b0}};
      for (i = 0; i < PIPE_D; i = i + 1) begin
        col_r[i] <= {COL_W{1'b0}};
        pba_r[i] <= 3'h0;
        pbeats_r[i] <= 4'h0;
      end
    end else begin
      mem_we <= 1'b0;
      mem_re <= 1'b0;
      cmd_error <= 1'b0;
      if (refresh_busy) begin
        if (rfc_cnt_r == 16'h1)
          refresh_busy <= 1'b0;
        rfc_cnt_r <= rfc_cnt_r - 16'h1;
      end
      // array word returns one cycle after its column is presented
      if (mem_re)
        dq_out <= mem_rdata;
      if (ck_rise) begin
        rd_p_r <= {rd_p_r[PIPE_D-2:0], 1'b0};
        wr_p_r <= {wr_p_r[PIPE_D-2:0], 1'b0};
        for (i = 1; i < PIPE_D; i = i + 1) begin
          col_r[i] <= col_r[i-1];
          pba_r[i] <= pba_r[i-1];
          pbeats_r[i] <= pbeats_r[i-1];
        end
        col_r[0] <= ccol;
        pba_r[0] <= cba;
        pbeats_r[0] <= beats_of(bl_mode, cchop);
        case (cmd)
          `DDRBR_CMD_ACT: begin
            bank_open[cba] <= 1'b1;
            open_row_r[cba] <= caddr[ROW_W-1:0];
          end
          `DDRBR_CMD_PRE: begin
            if (caddr[`DDRBR_AP_BIT])
              bank_open <= 8'h0;
            else
              bank_open[cba] <= 1'b0;
          end
          `DDRBR_CMD_REF: begin
            // internal row counter, external address ignored
            refresh_busy <= 1'b1;
            rfc_cnt_r <= RENEW_CYC;
            refresh_row <= refresh_row + {{(ROW_W-1){1'b0}}, 1'b1};
            bank_open <= 8'h0;
            if (bank_open != 8'h0)
              cmd_error <= 1'b1;
          end
          `DDRBR_CMD_RD: begin
            if (!bank_open[cba] || !dll_ok)
              cmd_error <= 1'b1;
            else
              rd_p_r[0] <= 1'b1;
            if (caddr[`DDRBR_AP_BIT])
              bank_open[cba] <= 1'b0;
          end
          `DDRBR_CMD_WR: begin
            if (!bank_open[cba])
              cmd_error <= 1'b1;
            else
              wr_p_r[0] <= 1'b1;
            if (caddr[`DDRBR_AP_BIT])
              bank_open[cba] <= 1'b0;
          end
          default: begin
          end
        endcase
        // burst engine: one beat per link clock edge
        if (rd_p_r[RD_TAP] && RD_TAP >= 0) begin
          dir_r <= 2'h1;
          beat_r <= 4'h0;
          blen_r <= pbeats_r[RD_TAP];
          bcol_r <= col_r[RD_TAP];
          bba_r <= pba_r[RD_TAP];
        end else if (wr_p_r[WR_TAP] && WR_TAP >= 0) begin
          dir_r <= 2'h2;
          beat_r <= 4'h0;
          blen_r <= pbeats_r[WR_TAP];
          bcol_r <= col_r[WR_TAP];
          bba_r <= pba_r[WR_TAP];
        end else if (dir_r != 2'h0) begin
          beat_r <= beat_r + 4'h1;
          if (beat_r + 4'h1 == blen_r)
            dir_r <= 2'h0;
        end
        if (dir_r == 2'h1 && dll_ok) begin
          mem_re <= 1'b1;
          dq_oe <= 1'b1;
        end else begin
          dq_oe <= 1'b0;
        end
        // bad strobe timing only yields wrong data at this column
        if (dir_r == 2'h2) begin
          mem_we <= 1'b1;
          mem_wdata <= d2_r;
        end
        if (dir_r != 2'h0) begin
          mem_ba <= bba_r;
          mem_row <= open_row_r[bba_r];
          mem_col <= bcol_r + {{(COL_W-4){1'b0}}, beat_r};
        end
      end
    end
  end
endmodule

// *** testbench/ddrbr_core_properties.sv ***
`timescale 1ns/1ns
`include "ddrbr_regs.vh"
module ddrbr_core_properties #(
  parameter ROW_W = 16
) (
  // watched ports
  input wire clk_sys,
  input wire rst,
  input wire dq_oe,
  input wire mem_re,
  input wire refresh_busy,
  input wire [ROW_W-1:0] refresh_row,
  input wire [7:0] bank_open,
  input wire cmd_error
);
  reg [7:0] busy_cnt_r;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) busy_cnt_r <= 8'h00;
    else busy_cnt_r <= refresh_busy ? busy_cnt_r + 8'h01 : 8'h00;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_ref_start; $rose(refresh_busy); endsequence
  sequence s_ref_hold; refresh_busy [*8]; endsequence
  property p_ref_hold; s_ref_start |-> s_ref_hold; endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("refresh busy too short");
  property p_busy_len; $fell(refresh_busy) |-> busy_cnt_r == `DDRBR_RENEW_CYC; endproperty
  a_busy_len: assert property (p_busy_len) else $error("refresh busy length");
  property p_busy_max; busy_cnt_r <= `DDRBR_RENEW_CYC; endproperty
  a_busy_max: assert property (p_busy_max) else $error("refresh busy overrun");
  property p_row_step; $changed(refresh_row) |-> refresh_row == $past(refresh_row) + 1'b1; endproperty
  a_row_step: assert property (p_row_step) else $error("refresh row step");
  property p_idle_ref; refresh_busy |-> bank_open == 8'h00; endproperty
  a_idle_ref: assert property (p_idle_ref) else $error("bank open in refresh");
  property p_beat_gap; mem_re |=> !mem_re [*6]; endproperty
  a_beat_gap: assert property (p_beat_gap) else $error("beats too close");
  property p_oe_stand; $rose(dq_oe) |-> dq_oe [*8]; endproperty
  a_oe_stand: assert property (p_oe_stand) else $error("read drive too short");
  property p_err_pulse; cmd_error |=> !cmd_error; endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("error not a pulse");
endmodule

// *** testbench/ddrbr_ctrl_model.sv ***
`timescale 1ns/1ns
module ddrbr_ctrl_model (
  // link pins
  output reg ck,
  output reg cs_n,
  output reg ras_n,
  output reg cas_n,
  output reg we_n,
  output reg [2:0] ba,
  output reg [15:0] addr,
  output reg [7:0] dq_in
);
  // link edges land on falling system clock edges
  initial begin
    ck = 1'b0;
    // no clock-enable pin: power-down and self-refresh entry are never made
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    ba = 3'h0;
    addr = 16'h0000;
    dq_in = 8'h00;
    #10;
    forever #40 ck = ~ck;
  end
  always @(posedge ck) dq_in <= dq_in + 8'h01;
  // one command per call, then deselect with scrambled address
  task issue(input [3:0] cmd, input [2:0] b, input [15:0] a);
    begin
      @(negedge ck);
      {cs_n, ras_n, cas_n, we_n} = cmd;
      ba = b;
      addr = a;
      @(negedge ck);
      cs_n = 1'b1;
      addr = ~a;
    end
  endtask
endmodule

// *** testbench/ddrbr_core_bench.sv ***
`timescale 1ns/1ns
`include "ddrbr_regs.vh"
module ddrbr_core_bench;
  reg clk_sys = 1'b0;
  reg rst = 1'b1;
  reg [1:0] bl_mode = 2'h0;
  reg dll_locked = 1'b1;
  reg err_seen = 1'b0;
  reg [9:0] first_col = 10'h000;
  reg [7:0] first_wdat = 8'h00;
  reg [7:0] wdat0 = 8'h00;
  integer wbeats = 0;
  reg [15:0] row0;
  reg [16:0] rows [0:3];
  integer mismatches = 0;
  integer total_checks = 0;
  integer cycles = 0;
  integer beats = 0;
  integer lat;
  integer i;
  wire ck, cs_n, ras_n, cas_n, we_n, dq_oe, mem_we, mem_re, refresh_busy, cmd_error;
  wire [2:0] ba, mem_ba;
  wire [15:0] addr, mem_row, refresh_row;
  wire [9:0] mem_col;
  wire [7:0] dq_in, dq_out, mem_wdata, bank_open;
  wire [7:0] mem_rdata = mem_col[7:0] ^ 8'h5a;
  ddrbr_ctrl_model ddrbr_ctrl_model_inst (.ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr), .dq_in(dq_in));
  ddrbr_core ddrbr_core_inst (.clk_sys(clk_sys), .rst(rst), .ck(ck), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .bl_mode(bl_mode), .dll_locked(dll_locked), .mem_we(mem_we),
    .mem_re(mem_re), .mem_ba(mem_ba), .mem_row(mem_row), .mem_col(mem_col),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .refresh_busy(refresh_busy),
    .refresh_row(refresh_row), .bank_open(bank_open), .cmd_error(cmd_error));
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (mem_re === 1'b1 && beats == 0) first_col <= mem_col;
    if (mem_re === 1'b1) beats <= beats + 1;
    if (mem_we === 1'b1 && wbeats == 0) first_wdat <= mem_wdata;
    if (mem_we === 1'b1) wbeats <= wbeats + 1;
    err_seen <= err_seen | cmd_error;
    if (cycles == 10000) begin
      mismatches = mismatches + 1;
      give_verdict;
    end
  end
  task check(input [31:0] seen, input [31:0] exp, input string what);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("mismatch %0s expected %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  task give_verdict;
    begin
      if (mismatches == 0 && total_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // read, then count link edges until the device drives
  task rd(input [2:0] b, input chop, input [9:0] col);
    begin
      beats = 0;
      err_seen = 1'b0;
      ddrbr_ctrl_model_inst.issue(`DDRBR_CMD_RD, b, {3'h0, chop, 2'h0, col});
      lat = 1;
      @(posedge ck);
      while (dq_oe !== 1'b1 && lat < 12) begin
        @(posedge ck);
        lat = lat + 1;
      end
      repeat (12) @(posedge ck);
    end
  endtask
  initial begin
    // mode, chop, column, beats
    rows[0] = {2'h0, 1'h0, 10'h010, 4'h8};
    rows[1] = {2'h1, 1'h1, 10'h3f8, 4'h8};
    rows[2] = {2'h1, 1'h0, 10'h020, 4'h4};
    rows[3] = {2'h2, 1'h1, 10'h100, 4'h4};
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    check(bank_open, 8'h00, "reset banks");
    ddrbr_ctrl_model_inst.issue(`DDRBR_CMD_ACT, 3'h1, 16'h0042);
    repeat (6) @(posedge ck);
    check(bank_open[1], 1'b1, "bank open");
    for (i = 0; i < 4; i = i + 1) begin
      bl_mode = rows[i][16:15];
      rd(3'h1, rows[i][14], rows[i][13:4]);
      check(lat, 7, "latency");
      check(beats, rows[i][3:0], "beats");
      check(first_col, rows[i][13:4], "first col");
      check(dq_out, (rows[i][11:4] + rows[i][3:0] - 8'h01) ^ 8'h5a, "last data");
    end
    dll_locked = 1'b0;
    rd(3'h1, 1'b1, 10'h000);
    check(beats, 0, "unlocked beats");
    check(err_seen, 1'b1, "unlocked error");
    dll_locked = 1'b1;
    rd(3'h2, 1'b1, 10'h000);
    check(beats, 0, "closed beats");
    check(err_seen, 1'b1, "closed error");
    // controller puts beat zero a write latency after the command
    bl_mode = 2'h1;
    wbeats = 0;
    err_seen = 1'b0;
    ddrbr_ctrl_model_inst.issue(`DDRBR_CMD_WR, 3'h1, 16'h1040);
    wdat0 = dq_in + 8'h05;
    repeat (16) @(posedge ck);
    check(wbeats, 8, "write beats");
    check(first_wdat, wdat0, "write data");
    check(err_seen, 1'b0, "write error");
    ddrbr_ctrl_model_inst.issue(`DDRBR_CMD_PRE, 3'h0, 16'h0400);
    repeat (4) @(posedge ck);
    check(bank_open, 8'h00, "banks closed");
    // two refreshes pulled in, well inside the budget of eight
    for (i = 0; i < 2; i = i + 1) begin
      row0 = refresh_row;
      ddrbr_ctrl_model_inst.issue(`DDRBR_CMD_REF, 3'h5, 16'hffff);
      @(posedge ck);
      check(refresh_busy, 1'b1, "refresh busy");
      check(refresh_row, row0 + 16'h0001, "refresh row");
      repeat (5) @(posedge ck);
      check(refresh_busy, 1'b0, "refresh done");
      check(bank_open, 8'h00, "idle after refresh");
    end
    give_verdict;
  end
endmodule
bind ddrbr_core ddrbr_core_properties #(.ROW_W(ROW_W)) ddrbr_core_properties_inst (
  .clk_sys(clk_sys), .rst(rst), .dq_oe(dq_oe), .mem_re(mem_re), .refresh_busy(refresh_busy),
  .refresh_row(refresh_row), .bank_open(bank_open), .cmd_error(cmd_error));
